// ==== hdl/status_sync_pkg.sv ====
// Constants for the remote status and synchronisation block
// Function
// - Query answers carry the bare value, no header prepended.
// - Special text quantities such as MAX or MIN answer as numbers.
// - Numeric answers carry no unit suffix.
// - Booleans answer 0 or 1; text settings answer short form.
// - Invalid values inside results are replaced by the not-a-number code.
// - A sequential command completes before the next one starts.
// - Sweep start is overlapped; completion bit waits for sweep end.
// - Clear during pending operation goes idle and drops the earlier completion request.
// - Completion request sets event bit 0 once prior commands finish.
// - Completion query stalls commands, then queues answer 1.
// - Wait command stalls further commands until prior ones finish.
// - Event enable bit 0 masks the completion event bit.
// - Service enable bit 5 gates the event summary; 32 sets it alone.
// - Service enable bit 4 gates message-available; 16 sets it alone.
// - Completion request then event read returns LSB 1 after finish.
// - Status byte and its service mask summarise everything at the top.
// - Status byte takes event, operation and questionable summaries.
// - Individual status flag condenses status under a parallel-poll mask.
// - Message-available bit follows output buffer holding data.
// - Five 16-bit parts per register; bit 15 always reads zero.
// - Event part latches edges only where transition filter bits allow.
// - Event reads return and clear; condition part is read-only.
// - Sum bit is OR of event AND enable, feeding the next level.
// - Service request rises on enabled status byte 0-to-1; enable bit 6 ignored.
`default_nettype none
package status_sync_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] ADDR_OPER_COND   = 8'h00;
    localparam logic [7:0] ADDR_OPER_PTR    = 8'h01;
    localparam logic [7:0] ADDR_OPER_NTR    = 8'h02;
    localparam logic [7:0] ADDR_OPER_EVENT  = 8'h03;
    localparam logic [7:0] ADDR_OPER_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_QUES_COND   = 8'h08;
    localparam logic [7:0] ADDR_QUES_PTR    = 8'h09;
    localparam logic [7:0] ADDR_QUES_NTR    = 8'h0a;
    localparam logic [7:0] ADDR_QUES_EVENT  = 8'h0b;
    localparam logic [7:0] ADDR_QUES_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_STD_EVENT   = 8'h10;
    localparam logic [7:0] ADDR_STD_ENABLE  = 8'h11;
    localparam logic [7:0] ADDR_STAT_BYTE   = 8'h12;
    localparam logic [7:0] ADDR_SRQ_ENABLE  = 8'h13;
    localparam logic [7:0] ADDR_PPOLL_EN    = 8'h14;
    localparam logic [7:0] ADDR_SYNC_STATE  = 8'h15;
    localparam logic [7:0] ADDR_COMMAND     = 8'h16;
    localparam logic [7:0] ADDR_RESPONSE    = 8'h17;

    // Field positions
    localparam int SR_WIDTH        = 16;
    localparam int SR_TOP_BIT      = 15;
    localparam int ESR_OPC_BIT     = 0;
    localparam int STB_ERRQ_BIT    = 2;
    localparam int STB_QUES_BIT    = 3;
    localparam int STB_MAV_BIT     = 4;
    localparam int STB_ESB_BIT     = 5;
    localparam int STB_RQS_BIT     = 6;
    localparam int STB_OPER_BIT    = 7;

    // Reset values
    localparam logic [15:0] SR_RESET   = 16'h0000;
    localparam logic [15:0] PTR_RESET  = 16'h7fff;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

    // Response codes
    localparam logic [15:0] RESP_ONE   = 16'h0001;
    localparam logic [15:0] RESP_NAN   = 16'hffff;

    // Command codes written to the command register
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_SEQ,
        CMD_SWEEP,
        CMD_OPC,
        CMD_OPC_QUERY,
        CMD_WAIT,
        CMD_CLEAR
    } cmd_type;

    // Synchronisation states
    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_OPC_ARMED,
        SYNC_QUERY_HOLD,
        SYNC_WAIT_HOLD
    } sync_state_type;
endpackage : status_sync_pkg
`default_nettype wire

// ==== hdl/status_reg_part.sv ====
// One five-part status register with transition filters and sum bit
`default_nettype none
`timescale 1ns/1ps
module status_reg_part (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] cond_i,
    input  wire logic        ptr_we_i,
    input  wire logic        ntr_we_i,
    input  wire logic        enable_we_i,
    input  wire logic        event_rd_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] cond_o,
    output logic      [15:0] ptr_o,
    output logic      [15:0] ntr_o,
    output logic      [15:0] event_o,
    output logic      [15:0] enable_o,
    output logic             sum_o
);
    typedef struct packed {
        logic [15:0] cond;
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic [15:0] event_bits;
        logic [15:0] enable;
    } part_state_type;

    part_state_type s_q;
    part_state_type s_d;
    logic [15:0]    clean_cond;
    logic [15:0]    edges;

    always_comb begin
        clean_cond = {1'b0, cond_i[14:0]};
        edges      = (clean_cond & ~s_q.cond & s_q.ptr)
                   | (~clean_cond & s_q.cond & s_q.ntr);
        s_d        = s_q;
        s_d.cond   = clean_cond;
        if (ptr_we_i) begin
            s_d.ptr = {1'b0, wdata_i[14:0]};
        end
        if (ntr_we_i) begin
            s_d.ntr = {1'b0, wdata_i[14:0]};
        end
        if (enable_we_i) begin
            s_d.enable = {1'b0, wdata_i[14:0]};
        end
        // New edges survive a clearing read
        s_d.event_bits = (event_rd_i ? 16'h0000 : s_q.event_bits) | edges;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '{cond: status_sync_pkg::SR_RESET, ptr: status_sync_pkg::PTR_RESET,
                     ntr: status_sync_pkg::SR_RESET, event_bits: status_sync_pkg::SR_RESET,
                     enable: status_sync_pkg::SR_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign cond_o   = s_q.cond;
    assign ptr_o    = s_q.ptr;
    assign ntr_o    = s_q.ntr;
    assign event_o  = s_q.event_bits;
    assign enable_o = s_q.enable;
    assign sum_o    = |(s_q.event_bits & s_q.enable);
endmodule : status_reg_part
`default_nettype wire

// ==== hdl/status_sync.sv ====
// Status hierarchy and command synchronisation engine
`default_nettype none
`timescale 1ns/1ps
module status_sync (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic [14:0] oper_cond_i,
    input  wire logic [14:0] ques_cond_i,
    input  wire logic        error_queue_i,
    input  wire logic        sweep_busy_i,
    input  wire logic        seq_busy_i,
    input  wire logic        resp_taken_i,
    output logic             sweep_start_o,
    output logic             seq_start_o,
    output logic             cmd_ready_o,
    output logic             srq_o,
    output logic             ist_o,
    output logic      [7:0]  status_byte_o
);
    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [15:0]                    rdata;
        logic [7:0]                     std_event;
        logic [7:0]                     std_enable;
        logic [7:0]                     srq_enable;
        logic [7:0]                     ppoll_enable;
        logic [7:0]                     stb_prev;
        logic                           srq;
        logic                           sweep_pending;
        logic                           seq_pending;
        status_sync_pkg::sync_state_type sync;
        logic [15:0]                    resp;
        logic                           resp_valid;
        logic                           sweep_start;
        logic                           seq_start;
    } top_state_type;

    top_state_type s_q;
    top_state_type s_d;

    logic        wr_oper_ptr;
    logic        wr_oper_ntr;
    logic        wr_oper_en;
    logic        wr_ques_ptr;
    logic        wr_ques_ntr;
    logic        wr_ques_en;
    logic        rd_oper_ev;
    logic        rd_ques_ev;
    logic [15:0] oper_cond;
    logic [15:0] oper_ptr;
    logic [15:0] oper_ntr;
    logic [15:0] oper_ev;
    logic [15:0] oper_en;
    logic        oper_sum;
    logic [15:0] ques_cond;
    logic [15:0] ques_ptr;
    logic [15:0] ques_ntr;
    logic [15:0] ques_ev;
    logic [15:0] ques_en;
    logic        ques_sum;

    // =========================================================
    // Operation and questionable registers
    // =========================================================
    assign wr_oper_ptr = wr_i && (addr_i == status_sync_pkg::ADDR_OPER_PTR);
    assign wr_oper_ntr = wr_i && (addr_i == status_sync_pkg::ADDR_OPER_NTR);
    assign wr_oper_en  = wr_i && (addr_i == status_sync_pkg::ADDR_OPER_ENABLE);
    assign wr_ques_ptr = wr_i && (addr_i == status_sync_pkg::ADDR_QUES_PTR);
    assign wr_ques_ntr = wr_i && (addr_i == status_sync_pkg::ADDR_QUES_NTR);
    assign wr_ques_en  = wr_i && (addr_i == status_sync_pkg::ADDR_QUES_ENABLE);
    assign rd_oper_ev  = rd_i && (addr_i == status_sync_pkg::ADDR_OPER_EVENT);
    assign rd_ques_ev  = rd_i && (addr_i == status_sync_pkg::ADDR_QUES_EVENT);

    status_reg_part u_oper (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .cond_i      ({1'b0, oper_cond_i}),
        .ptr_we_i    (wr_oper_ptr),
        .ntr_we_i    (wr_oper_ntr),
        .enable_we_i (wr_oper_en),
        .event_rd_i  (rd_oper_ev),
        .wdata_i     (wdata_i),
        .cond_o      (oper_cond),
        .ptr_o       (oper_ptr),
        .ntr_o       (oper_ntr),
        .event_o     (oper_ev),
        .enable_o    (oper_en),
        .sum_o       (oper_sum)
    );

    status_reg_part u_ques (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .cond_i      ({1'b0, ques_cond_i}),
        .ptr_we_i    (wr_ques_ptr),
        .ntr_we_i    (wr_ques_ntr),
        .enable_we_i (wr_ques_en),
        .event_rd_i  (rd_ques_ev),
        .wdata_i     (wdata_i),
        .cond_o      (ques_cond),
        .ptr_o       (ques_ptr),
        .ntr_o       (ques_ntr),
        .event_o     (ques_ev),
        .enable_o    (ques_en),
        .sum_o       (ques_sum)
    );

    // =========================================================
    // Status byte and summaries
    // =========================================================
    logic       esb;
    logic [7:0] stb_raw;
    logic [7:0] stb;
    logic       busy_all;

    always_comb begin
        esb = |(s_q.std_event & s_q.std_enable);
        stb_raw                                 = 8'h00;
        stb_raw[status_sync_pkg::STB_ERRQ_BIT]  = error_queue_i;
        stb_raw[status_sync_pkg::STB_QUES_BIT]  = ques_sum;
        stb_raw[status_sync_pkg::STB_MAV_BIT]   = s_q.resp_valid;
        stb_raw[status_sync_pkg::STB_ESB_BIT]   = esb;
        stb_raw[status_sync_pkg::STB_OPER_BIT]  = oper_sum;
        stb = stb_raw;
        stb[status_sync_pkg::STB_RQS_BIT] = s_q.srq;
    end

    assign busy_all = s_q.sweep_pending || s_q.seq_pending || sweep_busy_i || seq_busy_i;

    // =========================================================
    // Command engine and register file
    // =========================================================
    status_sync_pkg::cmd_type cmd;
    logic [7:0]               srq_mask;
    logic                     accept;

    always_comb begin
        cmd      = status_sync_pkg::cmd_type'(wdata_i[3:0]);
        srq_mask = s_q.srq_enable & 8'hbf;
        accept   = wr_i && (addr_i == status_sync_pkg::ADDR_COMMAND) && cmd_ready_o;
        s_d             = s_q;
        s_d.sweep_start = 1'b0;
        s_d.seq_start   = 1'b0;
        s_d.stb_prev    = stb_raw;

        // Pending work retires when the executing side goes idle
        if (s_q.sweep_pending && !s_q.sweep_start && !sweep_busy_i) begin
            s_d.sweep_pending = 1'b0;
        end
        if (s_q.seq_pending && !s_q.seq_start && !seq_busy_i) begin
            s_d.seq_pending = 1'b0;
        end

        // Synchronisation holds
        case (s_q.sync)
            status_sync_pkg::SYNC_OPC_ARMED: begin
                if (!busy_all) begin
                    s_d.sync = status_sync_pkg::SYNC_IDLE;
                    s_d.std_event[status_sync_pkg::ESR_OPC_BIT] = 1'b1;
                end
            end
            status_sync_pkg::SYNC_QUERY_HOLD: begin
                if (!busy_all) begin
                    s_d.sync       = status_sync_pkg::SYNC_IDLE;
                    s_d.resp       = status_sync_pkg::RESP_ONE;
                    s_d.resp_valid = 1'b1;
                end
            end
            status_sync_pkg::SYNC_WAIT_HOLD: begin
                if (!busy_all) begin
                    s_d.sync = status_sync_pkg::SYNC_IDLE;
                end
            end
            default: begin
            end
        endcase

        if (resp_taken_i) begin
            s_d.resp_valid = 1'b0;
        end

        // Register writes
        if (wr_i) begin
            if (addr_i == status_sync_pkg::ADDR_STD_ENABLE) begin
                s_d.std_enable = wdata_i[7:0];
            end else if (addr_i == status_sync_pkg::ADDR_SRQ_ENABLE) begin
                s_d.srq_enable = wdata_i[7:0];
            end else if (addr_i == status_sync_pkg::ADDR_PPOLL_EN) begin
                s_d.ppoll_enable = wdata_i[7:0];
            end
        end

        if (accept) begin
            case (cmd)
                status_sync_pkg::CMD_SEQ: begin
                    s_d.seq_start   = 1'b1;
                    s_d.seq_pending = 1'b1;
                end
                status_sync_pkg::CMD_SWEEP: begin
                    s_d.sweep_start   = 1'b1;
                    s_d.sweep_pending = 1'b1;
                end
                status_sync_pkg::CMD_OPC: begin
                    s_d.sync = status_sync_pkg::SYNC_OPC_ARMED;
                end
                status_sync_pkg::CMD_OPC_QUERY: begin
                    s_d.sync = status_sync_pkg::SYNC_QUERY_HOLD;
                end
                status_sync_pkg::CMD_WAIT: begin
                    s_d.sync = status_sync_pkg::SYNC_WAIT_HOLD;
                end
                status_sync_pkg::CMD_CLEAR: begin
                    // Armed completion request is dropped; sweep keeps running
                    s_d.sync      = status_sync_pkg::SYNC_IDLE;
                    s_d.std_event = status_sync_pkg::BYTE_RESET;
                end
                default: begin
                end
            endcase
        end

        // Register reads, data stand in the following cycle
        s_d.rdata = 16'h0000;
        if (rd_i) begin
            if (addr_i == status_sync_pkg::ADDR_OPER_COND) begin
                s_d.rdata = oper_cond;
            end else if (addr_i == status_sync_pkg::ADDR_OPER_PTR) begin
                s_d.rdata = oper_ptr;
            end else if (addr_i == status_sync_pkg::ADDR_OPER_NTR) begin
                s_d.rdata = oper_ntr;
            end else if (addr_i == status_sync_pkg::ADDR_OPER_EVENT) begin
                s_d.rdata = oper_ev;
            end else if (addr_i == status_sync_pkg::ADDR_OPER_ENABLE) begin
                s_d.rdata = oper_en;
            end else if (addr_i == status_sync_pkg::ADDR_QUES_COND) begin
                s_d.rdata = ques_cond;
            end else if (addr_i == status_sync_pkg::ADDR_QUES_PTR) begin
                s_d.rdata = ques_ptr;
            end else if (addr_i == status_sync_pkg::ADDR_QUES_NTR) begin
                s_d.rdata = ques_ntr;
            end else if (addr_i == status_sync_pkg::ADDR_QUES_EVENT) begin
                s_d.rdata = ques_ev;
            end else if (addr_i == status_sync_pkg::ADDR_QUES_ENABLE) begin
                s_d.rdata = ques_en;
            end else if (addr_i == status_sync_pkg::ADDR_STD_EVENT) begin
                s_d.rdata = {8'h00, s_q.std_event};
                // Completion set in this same cycle survives the clear
                s_d.std_event = (s_q.sync == status_sync_pkg::SYNC_OPC_ARMED && !busy_all)
                              ? 8'h01 : 8'h00;
            end else if (addr_i == status_sync_pkg::ADDR_STD_ENABLE) begin
                s_d.rdata = {8'h00, s_q.std_enable};
            end else if (addr_i == status_sync_pkg::ADDR_STAT_BYTE) begin
                s_d.rdata = {8'h00, stb};
            end else if (addr_i == status_sync_pkg::ADDR_SRQ_ENABLE) begin
                s_d.rdata = {8'h00, s_q.srq_enable};
            end else if (addr_i == status_sync_pkg::ADDR_PPOLL_EN) begin
                s_d.rdata = {8'h00, s_q.ppoll_enable};
            end else if (addr_i == status_sync_pkg::ADDR_SYNC_STATE) begin
                s_d.rdata = {12'h000, s_q.seq_pending, s_q.sweep_pending, s_q.sync};
            end else if (addr_i == status_sync_pkg::ADDR_RESPONSE) begin
                // Bare value, no header, no unit
                s_d.rdata = s_q.resp_valid ? s_q.resp : status_sync_pkg::RESP_NAN;
                s_d.resp_valid = 1'b0;
            end
        end

        // Request on an enabled rising status byte bit, held until no enabled status byte bit remains set
        if (|(stb_raw & ~s_q.stb_prev & srq_mask)) begin
            s_d.srq = 1'b1;
        end else if (!(|(stb_raw & srq_mask))) begin
            s_d.srq = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '{rdata: 16'h0000, std_event: 8'h00, std_enable: 8'h00,
                     srq_enable: 8'h00, ppoll_enable: 8'h00, stb_prev: 8'h00,
                     srq: 1'b0, sweep_pending: 1'b0, seq_pending: 1'b0,
                     sync: status_sync_pkg::SYNC_IDLE, resp: 16'h0000,
                     resp_valid: 1'b0, sweep_start: 1'b0, seq_start: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // Sequential work blocks intake until it retires
    assign cmd_ready_o   = (s_q.sync == status_sync_pkg::SYNC_IDLE
                            || s_q.sync == status_sync_pkg::SYNC_OPC_ARMED)
                           && !s_q.seq_pending && !s_q.seq_start;
    assign rdata_o       = s_q.rdata;
    assign sweep_start_o = s_q.sweep_start;
    assign seq_start_o   = s_q.seq_start;
    assign srq_o         = s_q.srq;
    assign ist_o         = |(stb & s_q.ppoll_enable);
    assign status_byte_o = stb;
endmodule : status_sync
`default_nettype wire

// ==== bench/exec_model.sv ====
// Executor model that answers start pulses with busy levels
`timescale 1ns/1ps
`default_nettype none
module exec_model #(parameter int BUSY_CYC = 20) (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic sweep_start_i,
    input  wire logic seq_start_i,
    output logic      sweep_busy_o,
    output logic      seq_busy_o
);
    int sw_q;
    int sq_q;
    // Sweep runs long so the block must overlap it; sequential work is short
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sw_q <= 0;
            sq_q <= 0;
        end else begin
            sw_q <= sweep_start_i ? BUSY_CYC : (sw_q > 0 ? sw_q - 1 : 0);
            sq_q <= seq_start_i ? 3 : (sq_q > 0 ? sq_q - 1 : 0);
        end
    end
    assign sweep_busy_o = sw_q > 0;
    assign seq_busy_o   = sq_q > 0;
endmodule : exec_model
`default_nettype wire

// ==== bench/status_sync_props.sv ====
// Port-level checks for the status and synchronisation block
`timescale 1ns/1ps
`default_nettype none
module status_sync_props (
    input wire logic        ref_clk_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [14:0] oper_cond_i,
    input wire logic [14:0] ques_cond_i,
    input wire logic        error_queue_i,
    input wire logic        sweep_start_o,
    input wire logic        seq_start_o,
    input wire logic        cmd_ready_o,
    input wire logic [7:0]  status_byte_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence cmd_wr(logic [15:0] code);
        wr_i && addr_i == status_sync_pkg::ADDR_COMMAND && wdata_i == code && cmd_ready_o;
    endsequence
    AST_SWEEP_START: assert property (cmd_wr(16'h0002) |=> sweep_start_o)
        else $error("sweep start pulse missing");
    AST_SWEEP_CAUSE: assert property (sweep_start_o |-> $past(wr_i) && $past(wdata_i) == 16'h0002)
        else $error("sweep start without command");
    AST_SEQ_START: assert property (cmd_wr(16'h0001) |=> seq_start_o)
        else $error("sequential start pulse missing");
    AST_SEQ_HOLD: assert property (seq_start_o |-> !cmd_ready_o ##1 !cmd_ready_o)
        else $error("command accepted during sequential work");
    AST_ERRQ_BIT: assert property (status_byte_o[2] == error_queue_i)
        else $error("error queue bit wrong");
    AST_TOP_BIT_ZERO: assert property ($past(rd_i && addr_i != status_sync_pkg::ADDR_RESPONSE) |-> !rdata_o[15])
        else $error("bit 15 read as one");
    AST_OPER_COND: assert property ($past(rd_i && addr_i == status_sync_pkg::ADDR_OPER_COND)
        |-> rdata_o == {1'b0, $past(oper_cond_i, 2)})
        else $error("operation condition read wrong");
    AST_QUES_COND: assert property ($past(rd_i && addr_i == status_sync_pkg::ADDR_QUES_COND)
        |-> rdata_o == {1'b0, $past(ques_cond_i, 2)})
        else $error("questionable condition read wrong");
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
endmodule : status_sync_props
bind status_sync status_sync_props u_props (.ref_clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .oper_cond_i, .ques_cond_i, .error_queue_i, .sweep_start_o, .seq_start_o, .cmd_ready_o, .status_byte_o);
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the status and synchronisation block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, error_queue_i = 0;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic [14:0] oper_cond_i = 15'h0000, ques_cond_i = 15'h0000;
    logic        sweep_busy, seq_busy, sweep_start_o, seq_start_o, cmd_ready_o, srq_o, ist_o;
    logic [7:0]  status_byte_o;
    int          errors = 0, cmp_count = 0;
    status_sync u_dut (.ref_clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .oper_cond_i,
        .ques_cond_i, .error_queue_i, .sweep_busy_i(sweep_busy), .seq_busy_i(seq_busy), .resp_taken_i(1'b0),
        .sweep_start_o, .seq_start_o, .cmd_ready_o, .srq_o, .ist_o, .status_byte_o);
    exec_model u_exec (.ref_clk_i, .sys_rst_i, .sweep_start_i(sweep_start_o), .seq_start_i(seq_start_o),
        .sweep_busy_o(sweep_busy), .seq_busy_o(seq_busy));

    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task end_sim;
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp, what);
    endtask : rd

    task wait_srq;
        int i;
        i = 0;
        while (!srq_o && i < 200) begin
            @(posedge ref_clk_i);
            #1;
            i++;
        end
        if (!srq_o) begin
            errors++;
            $display("ERROR %0t: service request timeout", $time);
            end_sim;
        end
    endtask : wait_srq

    task wait_ready;
        int i;
        i = 0;
        while (!cmd_ready_o && i < 200) begin
            @(posedge ref_clk_i);
            #1;
            i++;
        end
        if (!cmd_ready_o) begin
            errors++;
            $display("ERROR %0t: command intake timeout", $time);
            end_sim;
        end
    endtask : wait_ready

    task idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : idle

    task sc_reset;
        chk({15'h0000, cmd_ready_o}, 16'h0001, "ready after reset");
        chk({8'h00, status_byte_o}, 16'h0000, "status byte after reset");
        rd(status_sync_pkg::ADDR_OPER_PTR, 16'h7fff, "ptr reset");
    endtask : sc_reset

    task sc_filter;
        wr(status_sync_pkg::ADDR_OPER_PTR, 16'h0001);
        wr(status_sync_pkg::ADDR_OPER_ENABLE, 16'h0001);
        @(posedge ref_clk_i);
        oper_cond_i <= 15'h0001;
        idle(3);
        chk({15'h0000, status_byte_o[7]}, 16'h0001, "oper summary");
        rd(status_sync_pkg::ADDR_OPER_EVENT, 16'h0001, "rising edge latched");
        rd(status_sync_pkg::ADDR_OPER_EVENT, 16'h0000, "event cleared by read");
        rd(status_sync_pkg::ADDR_OPER_COND, 16'h0001, "condition unaffected");
        @(posedge ref_clk_i);
        oper_cond_i <= 15'h0000;
        idle(3);
        rd(status_sync_pkg::ADDR_OPER_EVENT, 16'h0000, "falling edge filtered");
    endtask : sc_filter

    task sc_opc_srq;
        wr(status_sync_pkg::ADDR_STD_ENABLE, 16'h0001);
        wr(status_sync_pkg::ADDR_SRQ_ENABLE, 16'h0020);
        wr(status_sync_pkg::ADDR_PPOLL_EN, 16'h0020);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0002);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0003);
        chk({15'h0000, status_byte_o[5]}, 16'h0000, "no early completion");
        wait_srq;
        chk({15'h0000, status_byte_o[5]}, 16'h0001, "event summary");
        chk({15'h0000, ist_o}, 16'h0001, "individual status");
        rd(status_sync_pkg::ADDR_STD_EVENT, 16'h0001, "completion bit");
        idle(1);
        chk({15'h0000, srq_o}, 16'h0000, "request drops after clear");
        rd(status_sync_pkg::ADDR_STD_EVENT, 16'h0000, "event cleared");
    endtask : sc_opc_srq

    task sc_query;
        wr(status_sync_pkg::ADDR_SRQ_ENABLE, 16'h0010);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0002);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0004);
        chk({15'h0000, cmd_ready_o}, 16'h0000, "query stalls intake");
        wait_srq;
        chk({15'h0000, status_byte_o[4]}, 16'h0001, "message available");
        rd(status_sync_pkg::ADDR_RESPONSE, 16'h0001, "query answer");
        rd(status_sync_pkg::ADDR_RESPONSE, 16'hffff, "empty answer code");
    endtask : sc_query

    task sc_clear_wait_seq;
        wr(status_sync_pkg::ADDR_SRQ_ENABLE, 16'h0000);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0002);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0003);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0006);
        idle(40);
        rd(status_sync_pkg::ADDR_STD_EVENT, 16'h0000, "completion dropped");
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0002);
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0005);
        chk({15'h0000, cmd_ready_o}, 16'h0000, "wait stalls intake");
        wait_ready;
        chk({15'h0000, sweep_busy}, 16'h0000, "sweep done before release");
        wr(status_sync_pkg::ADDR_COMMAND, 16'h0001);
        chk({15'h0000, cmd_ready_o}, 16'h0000, "sequential stalls intake");
        wait_ready;
        rd(status_sync_pkg::ADDR_SYNC_STATE, 16'h0000, "all retired");
    endtask : sc_clear_wait_seq

    initial begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        sc_reset;
        sc_filter;
        sc_opc_srq;
        sc_query;
        sc_clear_wait_seq;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
